// ==== verif/ahs_partner.sv ====
// Behavioural axis model: limit switches, reference cam, index and encoder
module ahs_partner
  import ahs_pkg::*;
#(
  parameter int LNEG = -40,
  parameter int LPOS = 40
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic move_en,
  input wire logic move_dir,
  input wire logic term_home,
  input wire logic jog, // Free travel outside homing runs
  input wire logic jog_dir, // Direction of free travel, 1 positive
  output ahs_pins_t pins,
  output logic signed [31:0] enc_pos
);
  timeunit 1ns;
  timeprecision 1ps;
  int pos; // Axis position in encoder counts
  logic [2:0] tick; // One count per eight cycles keeps pins stable
  ////////////////////////////////////////////////////////////////////////////
  // Axis travel while a homing motion or a jog is commanded
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pos <= 0;
      tick <= 3'h0;
    end
    else
    begin
      tick <= tick + 3'h1;
      if ((move_en || jog) && tick == 3'h7)
        pos <= (move_en ? move_dir : jog_dir) ? pos + 1 : pos - 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Pin levels from the position, index every sixteen counts
  always_comb
  begin
    pins.lim_neg = pos < LNEG;
    pins.lim_pos = pos > LPOS;
    pins.ref_cam = pos >= 8 && pos <= 20;
    pins.enc_index = (pos % 16) == 0;
    pins.term_home = term_home;
    enc_pos = pos;
  end
endmodule

// ==== verif/ahs_top_bench.sv ====
// Self-checking bench for the homing sequencer
module ahs_top_bench
  import ahs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 0;
  logic hresetn = 0;
  logic hsel = 0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic hready;
  ahs_pins_t pins;
  logic signed [31:0] enc_pos;
  logic signed [31:0] act_pos;
  logic homed;
  logic move_en;
  logic move_dir;
  logic [31:0] move_speed;
  logic term_home = 0;
  logic signed [31:0] corr_step;
  logic corr_valid;
  logic jog = 0; // Axis travel outside homing runs
  logic jog_dir = 0;
  int err_count = 0; // Mismatches seen
  int n_tests = 0; // Comparisons made
  int cyc = 0; // Cycle count for the hang guard
  int off; // Zero offset of the current run
  int rapid; // Seek speed setting
  int creep; // Slow approach setting
  int tt[8] = '{-1, -5, -5, 1, 2, -3, 1, 2}; // Types run in turn
  int tg[8] = '{0, 0, 0, 1, 2, 3, 4, 5}; // Start: command, fieldbus, terminal, endless, auto, set
  logic [31:0] d; // Read data
  assign hready = hreadyout; // Single slave bus
  always #4 hclk = ~hclk; // 125 MHz
  ahs_top u_ahs_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins), .enc_pos(enc_pos),
    .act_pos(act_pos), .homed(homed), .move_en(move_en), .move_dir(move_dir),
    .move_speed(move_speed), .corr_step(corr_step), .corr_valid(corr_valid));
  ahs_partner u_ahs_partner (.hclk(hclk), .hresetn(hresetn), .move_en(move_en),
    .move_dir(move_dir), .term_home(term_home), .jog(jog), .jog_dir(jog_dir), .pins(pins),
    .enc_pos(enc_pos));
  ////////////////////////////////////////////////////////////////////////////
  // Counts and verdict
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      err_count = err_count + 1;
      results();
    end
  end
  // One comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      err_count = err_count + 1;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // One AHB-Lite single word transfer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    xfer(1'b1, a, v, x);
  endtask
  // Settle past the edge
  task automatic tk(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // One referencing run and its result
  task automatic run(input int t, input int trig);
    int k;
    int rf;
    logic d0;
    logic seen;
    seen = 0;
    wr(OFS_ZOFF, 32'(off));
    wr(OFS_TYPE, 32'(t));
    if (trig == 0)
      wr(OFS_CTRL, 32'h120);
    else if (trig == 1)
      wr(OFS_CTRL, 32'h28);
    else if (trig == 2)
    begin
      @(posedge hclk);
      term_home <= 1'b1;
      tk(4);
      @(posedge hclk);
      term_home <= 1'b0;
    end
    else
      wr(OFS_CTRL, (trig == 3) ? 32'h124 : (trig == 4) ? 32'h31 : 32'h222);
    if (t > 0 || t == -3)
    begin
      for (k = 0; k < 20 && move_en !== 1'b1; k++)
        tk(1);
      chk(move_speed, 32'(rapid));
      chk(32'(move_dir), 32'(t == 2));
      d0 = move_dir;
      while (move_en === 1'b1)
      begin
        tk(1);
        if (move_en === 1'b1 && move_dir !== d0 && !seen)
        begin
          seen = 1;
          chk(move_speed, 32'(creep));
        end
      end
    end
    rf = (t == -5) ? 0 : (t == -1) ? int'(enc_pos) : (t == 1) ? -32 : (t == -3) ? 20 : 32;
    tk(4);
    chk(32'(homed), 32'h1);
    chk(act_pos, 32'(enc_pos - rf + off));
    if (trig == 1)
      wr(OFS_CTRL, 32'h20);
    else if (trig > 3)
    begin
      // Second control start or set selection must not home again
      wr(OFS_CTRL, (trig == 4) ? 32'h21 : 32'h22);
      wr(OFS_CTRL, (trig == 4) ? 32'h31 : 32'h222);
      tk(6);
      chk(32'(move_en), 32'h0);
    end
    else if (trig == 3)
    begin
      // Jog off the cam and back onto it: its rise reloads the offset
      @(posedge hclk);
      jog <= 1'b1;
      for (k = 0; k < 400 && enc_pos > 4; k++)
        tk(1);
      @(posedge hclk);
      jog_dir <= 1'b1;
      for (k = 0; k < 400 && corr_valid !== 1'b1; k++)
        tk(1);
      chk(32'(corr_valid), 32'h1);
      chk(corr_step, 32'(8 - 20));
      @(posedge hclk);
      jog <= 1'b0;
      tk(10);
      chk(act_pos, 32'(enc_pos - 8 + off));
    end
    $display("run of type %0d done", t);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    void'($urandom(32'h8c55d56f));
    rapid = $urandom_range(999, 500);
    creep = $urandom_range(99, 1);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, OFS_TYPE, 32'h0, d);
    chk(d, 32'hffff_ffff);
    wr(OFS_TYPE, 32'h24);
    xfer(1'b0, OFS_TYPE, 32'h0, d);
    chk(d, 32'hffff_ffff);
    wr(OFS_TYPE, 32'h101);
    xfer(1'b0, OFS_TYPE, 32'h0, d);
    chk(d, 32'hffff_ffff);
    xfer(1'b0, 8'h40, 32'h0, d);
    chk(d, 32'h0);
    chk(32'(hresp), 32'h0);
    $display("register map done");
    wr(OFS_RAPID, 32'(rapid));
    wr(OFS_CREEP, 32'(creep));
    foreach (tt[i])
    begin
      wr(OFS_TYPE, (i == 0) ? 32'h0 : 32'hffff_fffd);
      wr(OFS_CTRL, 32'h120);
      tk(3);
      chk(32'(move_en), 32'h0);
      chk(32'(homed), 32'h0);
      xfer(1'b0, OFS_STAT, 32'h0, d);
      chk(32'(d[1]), 32'h1);
      if (i == 1)
        break;
    end
    $display("refused types done");
    wr(OFS_TYPE, 32'h1);
    wr(OFS_CTRL, 32'h28);
    tk(12);
    chk(32'(move_en), 32'h1);
    wr(OFS_CTRL, 32'h20);
    tk(6);
    chk(32'(move_en), 32'h0);
    $display("fieldbus abort done");
    off = $urandom_range(900, 0) - 450;
    foreach (tt[i])
      run(tt[i], tg[i]);
    results();
  end
endmodule

// ==== verilog/ahs_ahb.sv ====
// AHB-Lite address phase decode for the homing registers
module ahs_ahb
  import ahs_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  output ahs_acc_t rd_acc,
  output ahs_acc_t wr_acc
);
  logic take; // Valid word transfer in address phase

  // Only whole word transfers are acted on
  assign take = hsel && htrans[1] && hready && (hsize == 3'h2);

  // Reads are served from the address phase
  always_comb
  begin
    rd_acc.rd = take && !hwrite;
    rd_acc.wr = 1'b0;
    rd_acc.word = haddr[7:2];
  end

  // Writes wait for hwdata in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wr_acc <= '0;
    else
    begin
      wr_acc.rd <= 1'b0;
      wr_acc.wr <= take && hwrite;
      wr_acc.word <= haddr[7:2];
    end
  end
endmodule

// ==== verilog/ahs_pkg.sv ====
// Shared constants, register map and types for the axis homing sequencer
package ahs_pkg;
  localparam int DW = 32;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TYPE = 8'h04;
  localparam logic [7:0] OFS_ZOFF = 8'h08;
  localparam logic [7:0] OFS_RAPID = 8'h0c;
  localparam logic [7:0] OFS_CREEP = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_POS = 8'h18;
  localparam logic [7:0] OFS_CORR = 8'h1c;
  // Control register bit positions
  localparam int CB_COND = 0;
  localparam int CB_ENDLESS = 2;
  localparam int CB_FBREQ = 3;
  localparam int CB_RUN = 4;
  localparam int CB_PWR = 5;
  localparam int CB_PLC = 8;
  localparam int CB_TSEL = 9;
  // Start condition codes
  localparam logic [1:0] COND_OFF = 2'h0;
  localparam logic [1:0] COND_AUTO = 2'h1;
  localparam logic [1:0] COND_TSET = 2'h2;
  // Referencing type codes and limits
  localparam logic signed [7:0] TYPE_MIN = 8'shfb;
  localparam logic signed [7:0] TYPE_MAX = 8'sh23;
  localparam logic signed [7:0] T_ABS = 8'shfb;
  localparam logic signed [7:0] T_CNEG = 8'shfc;
  localparam logic signed [7:0] T_CPOS = 8'shfd;
  localparam logic signed [7:0] T_NONE = 8'shfe;
  localparam logic signed [7:0] T_CLR = 8'shff;
  localparam logic signed [7:0] T_IDX_MAX = 8'sh0a;
  localparam logic signed [7:0] T_CAM20 = 8'sh14;
  localparam logic signed [7:0] T_CAM22 = 8'sh16;
  // Values after reset
  localparam logic signed [7:0] TYPE_RST = 8'shff;
  localparam logic [31:0] SPEED_RST = 32'h0000_0014;
  localparam logic [31:0] ZOFF_RST = 32'h0000_0000;
  localparam logic [1:0] COND_RST = 2'h0;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEEK = 3'b001,
    ST_CREEP = 3'b010,
    ST_INDEX = 3'b011
  } ahs_state_t;
  // Reference signal selection
  typedef enum logic [1:0] {SEL_NEG = 2'b00, SEL_POS = 2'b01, SEL_CAM = 2'b10} ahs_sel_t;
  // Class of a referencing type
  typedef enum logic [1:0] {K_BAD = 2'b00, K_ABS = 2'b01, K_CLR = 2'b10, K_MOVE = 2'b11} ahs_kind_t;
  // Motion plan of one referencing run
  typedef struct packed {
    ahs_sel_t sel;
    logic dir1;
    logic pol1;
    logic rev;
    logic idx;
  } ahs_plan_t;
  // Reference pins from the machine
  typedef struct packed {
    logic term_home;
    logic enc_index;
    logic ref_cam;
    logic lim_pos;
    logic lim_neg;
  } ahs_pins_t;
  // Decoded bus access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] word;
  } ahs_acc_t;
endpackage

// ==== verilog/ahs_sync.sv ====
// Two-stage synchroniser for the reference pins
module ahs_sync
  import ahs_pkg::*;
#(
  parameter int W = 5
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r; // First stage, read only by q

  // Double flop into the clock domain
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ==== verilog/ahs_top.sv ====
// Homing sequencer core with register file and assertions
//
// Summary of operation
// - start condition 0: fieldbus level requests on/off
// - terminal and command start on rising edge
// - every accepted request starts a new run
// - condition 1: run once at first control start
// - condition 2: run once at first travel set
// - type -5 references at power-up, no motion
// - repeated -5 with same offset keeps position
// - types -3/-4 only with endless travel
// - continuous mode: cam rise reloads zero offset
// - -3 runs like 22, -4 like 20
// - correction is a step, no ramp
// - type -2 adds offset, homed at power on
// - type -1 clears position then adds offset
// - type 1: negative switch, reverse, index
// - type 2: positive switch, reverse, index
// - type 3 cam off: positive, reverse, index
// - type 4 cam off: positive, index after rise
// - types 3/4 cam on: move negative
// - types 5/6 cam on: move positive
// - types 5/6 cam off: move negative
// - types 7-10 start toward positive switch
// - watch both switches, cam and index; code watches only the plan's one selected signal and the index
// - type accepts -5 to 35, resets to -1
// - every zero point includes the offset
// - rapid speed first, creep after first event
// - type 7 reverses on cam, index after fall
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
module ahs_top
  import ahs_pkg::*;
#(
  parameter logic signed [7:0] TYPE_INIT = TYPE_RST
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [DW-1:0] hwdata,
  output logic [DW-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire ahs_pins_t pins,
  input wire logic signed [31:0] enc_pos,
  output logic signed [31:0] act_pos,
  output logic homed,
  output logic move_en,
  output logic move_dir,
  output logic [31:0] move_speed,
  output logic signed [31:0] corr_step,
  output logic corr_valid
);
  ////////////////////////////////////////////////////////////////////////
  // Declarations
  ahs_acc_t rd_acc; // Read in address phase
  ahs_acc_t wr_acc; // Write in data phase
  ahs_pins_t pin_s; // Synchronised pins
  ahs_pins_t pin_p; // Previous synchronised pins
  logic [1:0] cond_r; // Start condition
  logic endless_r; // Endless travel range
  logic fb_req_r; // Fieldbus request level
  logic run_r; // Control started
  logic pwr_r; // Power stage on
  logic plc_cmd_r; // Go-home command pulse
  logic tsel_r; // Travel set selected pulse
  logic signed [7:0] type_r; // Referencing type
  logic signed [31:0] zoff_r; // Zero offset
  logic [31:0] rapid_r; // Rapid speed
  logic [31:0] creep_r; // Creep speed
  logic set_chg; // Settings rewritten
  logic fb_p, run_p, pwr_p; // Previous control levels
  logic boot_r; // First cycle after reset
  logic once_r; // Automatic run already done
  logic pwr_seen_r; // Power stage enabled once
  ahs_state_t state_r; // Sequencer state
  ahs_plan_t plan_r; // Plan of current run
  logic dir_r; // Travel direction, 1 positive
  logic run_cont_r; // Run ends in continuous mode
  logic cont_r; // Continuous correction active
  logic err_r; // Last start rejected
  logic signed [31:0] base_r; // Encoder count of zero
  logic start_req, go, abort, zero_hit, cam_fix, pwr_first;
  logic sig_now, sig_old, ev1, ev2, idx_rise, cam_rise;
  ahs_kind_t kind;
  ahs_plan_t plan_now;

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  // Class of a referencing type
  function automatic ahs_kind_t kind_of(input logic signed [7:0] t, input logic endl);
    if (t == T_ABS || t == T_NONE)
      kind_of = K_ABS;
    else if (t == T_CLR)
      kind_of = K_CLR;
    else if (t == T_CPOS || t == T_CNEG)
      kind_of = endl ? K_MOVE : K_BAD;
    else if ((t > 0 && t <= T_IDX_MAX) || t == T_CAM20 || t == T_CAM22)
      kind_of = K_MOVE;
    else
      kind_of = K_BAD; // Type 0 and unsupported types
  endfunction

  // Signal, direction and edges for each motion type
  function automatic ahs_plan_t plan_of(input logic signed [7:0] t, input logic cam);
    ahs_plan_t p;
    p = '{SEL_CAM, 1'b1, 1'b1, 1'b1, 1'b1}; // Type 3 cam off, 7 to 10
    case (t)
      8'sh01: p = '{SEL_NEG, 1'b0, 1'b1, 1'b1, 1'b1};
      8'sh02: p = '{SEL_POS, 1'b1, 1'b1, 1'b1, 1'b1};
      8'sh03:
        if (cam)
          p = '{SEL_CAM, 1'b0, 1'b0, 1'b0, 1'b1};
      8'sh04, T_CAM20, T_CNEG:
        p = cam ? '{SEL_CAM, 1'b0, 1'b0, 1'b1, 1'b1} : '{SEL_CAM, 1'b1, 1'b1, 1'b0, 1'b1};
      8'sh05:
        p = cam ? '{SEL_CAM, 1'b1, 1'b0, 1'b0, 1'b1} : '{SEL_CAM, 1'b0, 1'b1, 1'b1, 1'b1};
      8'sh06, T_CAM22, T_CPOS:
        p = cam ? '{SEL_CAM, 1'b1, 1'b0, 1'b1, 1'b1} : '{SEL_CAM, 1'b0, 1'b1, 1'b0, 1'b1};
      default: ;
    endcase
    p.idx = (t > 0 && t <= T_IDX_MAX); // Cam-only types skip the index
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus decode and pin synchronisers
  ahs_ahb u_ahb (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr[7:0]),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .rd_acc(rd_acc),
    .wr_acc(wr_acc)
  );

  ahs_sync #(.W(5)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(pins),
    .q(pin_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cond_r <= COND_RST;
      endless_r <= 1'b0;
      fb_req_r <= 1'b0;
      run_r <= 1'b0;
      pwr_r <= 1'b0;
      plc_cmd_r <= 1'b0;
      tsel_r <= 1'b0;
      type_r <= TYPE_INIT;
      zoff_r <= ZOFF_RST;
      rapid_r <= SPEED_RST;
      creep_r <= SPEED_RST;
    end
    else
    begin
      plc_cmd_r <= 1'b0;
      tsel_r <= 1'b0;
      if (wr_acc.wr)
      begin
        case ({wr_acc.word, 2'b00})
          OFS_CTRL:
          begin
            cond_r <= hwdata[CB_COND +: 2];
            endless_r <= hwdata[CB_ENDLESS];
            fb_req_r <= hwdata[CB_FBREQ];
            run_r <= hwdata[CB_RUN];
            pwr_r <= hwdata[CB_PWR];
            plc_cmd_r <= hwdata[CB_PLC];
            tsel_r <= hwdata[CB_TSEL];
          end
          OFS_TYPE: // Out of range values keep the old type
            if ($signed(hwdata) >= TYPE_MIN && $signed(hwdata) <= TYPE_MAX)
              type_r <= hwdata[7:0];
          OFS_ZOFF: zoff_r <= hwdata;
          OFS_RAPID: rapid_r <= hwdata;
          OFS_CREEP: creep_r <= hwdata;
          default: ; // Read-only and unmapped words
        endcase
      end
    end
  end

  // Rewriting type or offset re-arms the automatic start
  assign set_chg = wr_acc.wr && ({wr_acc.word, 2'b00} == OFS_TYPE ||
                                 {wr_acc.word, 2'b00} == OFS_ZOFF);

  ////////////////////////////////////////////////////////////////////////
  // Register reads and bus answer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (rd_acc.rd)
    begin
      case ({rd_acc.word, 2'b00})
        OFS_CTRL: hrdata <= {26'h0, pwr_r, run_r, fb_req_r, endless_r, cond_r};
        OFS_TYPE: hrdata <= {{24{type_r[7]}}, type_r};
        OFS_ZOFF: hrdata <= zoff_r;
        OFS_RAPID: hrdata <= rapid_r;
        OFS_CREEP: hrdata <= creep_r;
        OFS_STAT: hrdata <= {25'h0, state_r, 1'b0, cont_r, err_r, homed};
        OFS_POS: hrdata <= act_pos;
        OFS_CORR: hrdata <= corr_step;
        default: hrdata <= '0; // Unmapped words read zero
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Edges and start requests
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_p <= '0;
      fb_p <= 1'b0;
      run_p <= 1'b0;
      pwr_p <= 1'b0;
      boot_r <= 1'b1;
    end
    else
    begin
      pin_p <= pin_s;
      fb_p <= fb_req_r;
      run_p <= run_r;
      pwr_p <= pwr_r;
      boot_r <= 1'b0;
    end
  end

  // Start on edges or write pulses per start condition
  always_comb
  begin
    start_req = 1'b0;
    case (cond_r)
      COND_OFF:
        start_req = (fb_req_r && !fb_p) || (pin_s.term_home && !pin_p.term_home) || plc_cmd_r;
      COND_AUTO: start_req = run_r && !run_p && !once_r;
      COND_TSET: start_req = tsel_r && !once_r;
      default: start_req = 1'b0;
    endcase
    if (boot_r && type_r == T_ABS)
      start_req = 1'b1; // Referenced at power-up, power stage not needed
  end

  assign go = (state_r == ST_IDLE) && start_req;
  assign abort = (cond_r == COND_OFF) && !fb_req_r && fb_p && (state_r != ST_IDLE);
  assign kind = kind_of(type_r, endless_r);
  assign plan_now = plan_of(type_r, pin_s.ref_cam);
  assign pwr_first = pwr_r && !pwr_p && !pwr_seen_r && type_r == T_NONE;

  // Reference signal chosen by the plan
  always_comb
  begin
    case (plan_r.sel)
      SEL_NEG: {sig_now, sig_old} = {pin_s.lim_neg, pin_p.lim_neg};
      SEL_POS: {sig_now, sig_old} = {pin_s.lim_pos, pin_p.lim_pos};
      default: {sig_now, sig_old} = {pin_s.ref_cam, pin_p.ref_cam};
    endcase
  end

  assign ev1 = plan_r.pol1 ? (sig_now && !sig_old) : (!sig_now && sig_old);
  assign ev2 = plan_r.pol1 ? (!sig_now && sig_old) : (sig_now && !sig_old);
  assign idx_rise = pin_s.enc_index && !pin_p.enc_index;
  assign cam_rise = pin_s.ref_cam && !pin_p.ref_cam;
  assign zero_hit = !abort && ((state_r == ST_SEEK && ev1 && !plan_r.rev && !plan_r.idx) ||
                    (state_r == ST_CREEP && ev2 && !plan_r.idx) ||
                    (state_r == ST_INDEX && idx_rise));
  assign cam_fix = cont_r && (state_r == ST_IDLE) && cam_rise;

  ////////////////////////////////////////////////////////////////////////
  // Homing sequencer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= ST_IDLE;
      plan_r <= '0;
      dir_r <= 1'b0;
      run_cont_r <= 1'b0;
    end
    else if (abort)
      state_r <= ST_IDLE; // Fieldbus level dropped
    else
    begin
      case (state_r)
        ST_IDLE:
          if (go && kind == K_MOVE)
          begin
            plan_r <= plan_now;
            dir_r <= plan_now.dir1;
            run_cont_r <= (type_r == T_CPOS || type_r == T_CNEG);
            state_r <= ST_SEEK;
          end
        ST_SEEK: // Rapid run to the first event
          if (ev1)
          begin
            if (plan_r.rev)
            begin
              dir_r <= !dir_r;
              state_r <= ST_CREEP;
            end
            else
              state_r <= plan_r.idx ? ST_INDEX : ST_IDLE;
          end
        ST_CREEP: // Creep back to the opposite edge
          if (ev2)
            state_r <= plan_r.idx ? ST_INDEX : ST_IDLE;
        ST_INDEX: // First index pulse is the zero point
          if (idx_rise)
            state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Drive command, rapid before the first event, creep after
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      move_en <= 1'b0;
      move_dir <= 1'b0;
      move_speed <= '0;
    end
    else
    begin
      move_en <= (state_r != ST_IDLE);
      move_dir <= dir_r;
      move_speed <= (state_r == ST_SEEK) ? rapid_r : creep_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Position reference and continuous correction
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      base_r <= '0;
      act_pos <= '0;
      corr_step <= '0;
      corr_valid <= 1'b0;
    end
    else
    begin
      corr_valid <= 1'b0;
      act_pos <= enc_pos - base_r;
      if ((go && kind == K_ABS) || pwr_first)
        base_r <= -zoff_r; // Encoder plus offset, stable on repeat
      else if ((go && kind == K_CLR) || zero_hit)
        base_r <= enc_pos - zoff_r; // Zero here plus offset
      else if (cam_fix)
      begin
        base_r <= enc_pos - zoff_r;
        corr_step <= act_pos - zoff_r; // Step for the trailing-error loop
        corr_valid <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      homed <= 1'b0;
      err_r <= 1'b0;
      cont_r <= 1'b0;
      once_r <= 1'b0;
      pwr_seen_r <= 1'b0;
    end
    else
    begin
      if (pwr_r && !pwr_p)
        pwr_seen_r <= 1'b1;
      if (go && cond_r != COND_OFF)
        once_r <= 1'b1; // Set wins over a settings rewrite
      else if (set_chg)
        once_r <= 1'b0;
      if (go)
      begin
        err_r <= (kind == K_BAD);
        cont_r <= 1'b0;
      end
      else if (zero_hit && run_cont_r)
        cont_r <= 1'b1;
      if (zero_hit || pwr_first || (go && (kind == K_CLR || (kind == K_ABS &&
          (type_r == T_ABS || pwr_seen_r)))))
        homed <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_TYPE_ZERO: assert property (go && type_r == 8'sh00 |=> state_r == ST_IDLE && err_r)
    else $error("type 0 was not rejected");
  AST_ENDLESS: assert property (go && type_r == T_CPOS && !endless_r |=> !move_en [*2])
    else $error("continuous type ran without endless range");
  AST_CAM_FIX: assert property (cam_fix |=> corr_valid && base_r == $past(enc_pos) - $past(zoff_r))
    else $error("cam edge did not reload offset");
  AST_LEVEL_OFF: assert property (abort |=> state_r == ST_IDLE ##1 !move_en)
    else $error("fieldbus level off did not stop run");
  AST_RAPID: assert property (state_r == ST_SEEK |=> move_speed == $past(rapid_r) && move_en)
    else $error("seek not at rapid speed");
  AST_HOMED: assert property (zero_hit |=> homed && state_r == ST_IDLE)
    else $error("zero point did not set homed");
  AST_ONCE: assert property (cond_r == COND_AUTO && once_r && !boot_r |-> !start_req)
    else $error("automatic start repeated");
  AST_ABS_BOOT: assert property (boot_r && type_r == T_ABS |=> homed && base_r == -$past(zoff_r))
    else $error("absolute type not referenced at power-up");
  AST_REVERSE: assert property (state_r == ST_SEEK && ev1 && plan_r.rev && !abort
    |=> state_r == ST_CREEP && dir_r != $past(dir_r) ##1 move_dir == $past(dir_r))
    else $error("no reversal at first event");
  AST_TERM: assert property (cond_r == COND_OFF && state_r == ST_IDLE && $rose(pin_s.term_home)
    && kind == K_MOVE |=> state_r == ST_SEEK)
    else $error("terminal edge did not start referencing");
endmodule
